//--- common/charge_seq_pkg.sv
package charge_seq_pkg;
   // register map and field layout
   localparam logic [7:0] CHARGE_CONTROL_ADDR = 8'h02;
   localparam logic [7:0] CHARGE_CONTROL_RST  = 8'h04;
   localparam int CTL_RESET_BIT   = 7;  // self-clearing restart request
   localparam int CTL_HIZ_BIT     = 3;  // high_impedance_select
   localparam int CTL_TERM_BIT    = 2;  // taper_cutoff_allow
   localparam int CTL_DISABLE_BIT = 1;  // charge disable
   localparam int CTL_STATEN_BIT  = 0;  // status pin enable
   localparam logic [7:0] CTL_WR_MASK = 8'h0f;

   // timing
   localparam int CLK_MHZ       = 200;
   localparam int ALERT_US      = 128;
   localparam int ALERT_CYCLES  = ALERT_US * CLK_MHZ;
   localparam int PROBE_US      = 250000;
   localparam int PROBE_CYCLES  = PROBE_US * CLK_MHZ;
   localparam int DEGLITCH_US   = 250;
   localparam int DEGLITCH_CYCLES = DEGLITCH_US * CLK_MHZ;
   localparam int RAMP_STEP_CYCLES = 256;
   localparam int CUR_W = 8;

   typedef enum logic [7:0] {
      ST_SHORTED  = 8'h01,
      ST_PRECHG   = 8'h02,
      ST_FAST     = 8'h04,
      ST_CVREG    = 8'h08,
      ST_DET_SINK = 8'h10,
      ST_DET_SRC  = 8'h20,
      ST_DONE     = 8'h40,
      ST_SUPPLY   = 8'h80
   } chg_state_t;

   // analog comparator results from the sense front end
   typedef struct packed {
      logic inputValid;
      logic cellBelowShort;
      logic loadAboveReg;
      logic loadAtMin;
      logic cellNearFloat;
      logic currentAtCutoff;
      logic cellAboveRecharge;
      logic cellAboveProbe;
      logic cellOverVolt;
      logic cellAboveUvlo;
      logic shortLimit;
      logic loadGrowing;
   } sense_t;

   // analog actuator commands
   typedef struct packed {
      logic buckOn;
      logic battSwitchOn;
      logic battSwitchLinear;
      logic shortCurOn;
      logic probeSinkOn;
      logic cellPinHiz;
      logic taperOn;
   } drive_t;

   // register read and write request port
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic       battAbsent;
      logic       overVolt;
      logic       newSupply;
      logic       faultAny;
   } status_t;
endpackage

//--- rtl/interval_timer.sv
`timescale 1ns/1ps
module interval_timer #(
   parameter int CNT_W = 24
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_b,
   // control
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] length,
   // status
   output logic                  busy,
   output logic                  done
);
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   logic             busy_ff;
   logic             nxt_busy;
   logic             done_ff;
   logic             nxt_done;

   // restart wins over a running count so a retrigger never extends silently
   always_comb begin
      nxt_count = count_ff;
      nxt_busy  = busy_ff;
      nxt_done  = 1'b0;
      if (start) begin
         nxt_count = length;
         nxt_busy  = 1'b1;
      end else if (busy_ff) begin
         if (count_ff <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
         end else begin
            nxt_count = count_ff - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count_ff <= '0;
         busy_ff  <= 1'b0;
         done_ff  <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         busy_ff  <= nxt_busy;
         done_ff  <= nxt_done;
      end
   end

   assign busy = busy_ff;
   assign done = done_ff;
endmodule

//--- rtl/charge_cycle_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - below shorted threshold: drive recovery current, timer restarted each interval, linear switch, regulate rail
// - above shorted threshold: regulate programmed current, switch linear to hold rail
// - load rail above regulation level: switch fully on, full fast-charge current
// - fast-charge current ramps at a controlled slew rate
// - float voltage programmable; current tapers near it
// - cutoff current and above recharge level ends charge, enters detection
// - termination bit zero disables termination and detection
// - recharge, input toggle, disable toggle, reset bit, hi-z toggle restart charging
// - sink phase: cell stays above probe threshold whole interval means present, done
// - cell falls in sink phase: flag absent, then source recovery current
// - source phase: cell reaches threshold, source off, sink after interval
// - detection repeats until disabled or found; found clears fault, restarts
// - valid input: start buck, alert pulse, faults normal, new supply reported
// - charge-disable is bit 1 of control at 0x02, default 0
// - disable set with input: switch off, rail regulated, charge after clear
// - rail at minimum: cut current; at zero with growing load, supplement
// - cell five percent over float: stop buck, switch on, report over-voltage
// - battery only: switch on, short limit turns off deglitch time, retry
// - cell below lockout without input: switch off, cell pin high impedance
// - status pin low while charging, released when done, pulse on fault
module charge_cycle_sequencer
   import charge_seq_pkg::*;
#(
   parameter int ALERT_LEN    = ALERT_CYCLES,
   parameter int PROBE_LEN    = PROBE_CYCLES,
   parameter int DEGLITCH_LEN = DEGLITCH_CYCLES,
   parameter int RAMP_STEP    = RAMP_STEP_CYCLES
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst_b,
   // register access from the serial interface block
   input  charge_seq_pkg::reg_req_t      regReq,
   output logic [7:0]                    regRdata,
   // programmed values held by neighbouring registers
   input  wire logic [CUR_W-1:0]         chargeCurrentSet,
   input  wire logic [5:0]               floatVoltageSet,
   // analog comparators
   input  charge_seq_pkg::sense_t        senseIn,
   // analog actuators
   output charge_seq_pkg::drive_t        driveOut,
   output logic [CUR_W-1:0]              chargeCurrentCmd,
   output logic [5:0]                    floatVoltageCmd,
   // status
   output charge_seq_pkg::status_t       statusOut,
   output charge_seq_pkg::chg_state_t    chargeState,
   output logic                          statPinOe_b
);
   import charge_seq_pkg::*;

   // wide enough for the full probe interval at the default clock
   localparam int TW = 26;

   // comparators are asynchronous to mclk
   sense_t senseMeta_ff;
   sense_t senseSync_ff;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         senseMeta_ff <= '0;
         senseSync_ff <= '0;
      end else begin
         senseMeta_ff <= senseIn;
         senseSync_ff <= senseMeta_ff;
      end
   end

   function automatic logic bitOf(input logic [7:0] v, input int idx);
      return v[idx];
   endfunction

   // control register
   logic [7:0] control_ff;
   logic [7:0] nxt_control;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic       ctlWrite;
   assign ctlWrite = regReq.wrEn && (regReq.addr == CHARGE_CONTROL_ADDR);

   always_comb begin
      nxt_control = control_ff;
      nxt_control[CTL_RESET_BIT] = 1'b0; // reset bit self clears
      if (ctlWrite) begin
         nxt_control = (regReq.wdata & CTL_WR_MASK)
                     | (regReq.wdata & (8'h01 << CTL_RESET_BIT));
      end
      nxt_rdata = rdata_ff;
      if (regReq.rdEn) begin
         nxt_rdata = (regReq.addr == CHARGE_CONTROL_ADDR) ? control_ff : 8'h00;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         control_ff <= CHARGE_CONTROL_RST;
         rdata_ff   <= 8'h00;
      end else begin
         control_ff <= nxt_control;
         rdata_ff   <= nxt_rdata;
      end
   end

   logic disableBit;
   logic termAllow;
   logic hizSel;
   logic statEn;
   assign disableBit = bitOf(control_ff, CTL_DISABLE_BIT);
   assign termAllow  = bitOf(control_ff, CTL_TERM_BIT);
   assign hizSel     = bitOf(control_ff, CTL_HIZ_BIT);
   assign statEn     = bitOf(control_ff, CTL_STATEN_BIT);

   // edge history for restart causes
   logic prevInput_ff;
   logic prevDisable_ff;
   logic prevHiz_ff;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         prevInput_ff   <= 1'b0;
         prevDisable_ff <= 1'b0;
         prevHiz_ff     <= 1'b0;
      end else begin
         prevInput_ff   <= senseSync_ff.inputValid;
         prevDisable_ff <= disableBit;
         prevHiz_ff     <= hizSel;
      end
   end

   logic inputRise;
   logic restartReq;
   logic mayCharge;
   assign inputRise = senseSync_ff.inputValid && !prevInput_ff;
   assign restartReq = (senseSync_ff.inputValid != prevInput_ff)
                     || (disableBit != prevDisable_ff)
                     || bitOf(control_ff, CTL_RESET_BIT)
                     || (hizSel != prevHiz_ff);
   assign mayCharge = senseSync_ff.inputValid && !disableBit && !hizSel;

   // probe and deglitch timers share one counter module
   logic          tmrStart;
   logic [TW-1:0] tmrLen;
   logic          tmrBusy;
   logic          tmrDone;
   interval_timer #(.CNT_W(TW)) u_timer (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .start  (tmrStart),
      .length (tmrLen),
      .busy   (tmrBusy),
      .done   (tmrDone)
   );

   // charge state machine
   chg_state_t state_ff;
   chg_state_t nxt_state;
   logic       absent_ff;
   logic       nxt_absent;
   logic       srcOff_ff;
   logic       nxt_srcOff;
   logic       alertReq;
   logic       ovp_ff;

   always_comb begin
      nxt_state  = state_ff;
      nxt_absent = absent_ff;
      nxt_srcOff = srcOff_ff;
      tmrStart   = 1'b0;
      tmrLen     = TW'(PROBE_LEN);
      alertReq   = 1'b0;
      if (restartReq || !mayCharge) begin
         nxt_state  = senseSync_ff.cellBelowShort ? ST_SHORTED : ST_PRECHG;
         nxt_srcOff = 1'b0;
         tmrStart   = senseSync_ff.cellBelowShort;
         if (!mayCharge) begin
            nxt_absent = 1'b0;
         end
      end else begin
         case (state_ff)
            ST_SHORTED: begin
               if (!senseSync_ff.cellBelowShort) begin
                  nxt_state = ST_PRECHG;
               end else if (tmrDone) begin
                  tmrStart = 1'b1;
               end
            end
            ST_PRECHG: begin
               if (senseSync_ff.cellBelowShort) begin
                  nxt_state = ST_SHORTED;
                  tmrStart  = 1'b1;
               end else if (senseSync_ff.loadAboveReg) begin
                  nxt_state = ST_FAST;
               end
            end
            ST_FAST: begin
               if (senseSync_ff.loadAtMin && chargeCurrentCmd == '0
                   && senseSync_ff.loadGrowing) begin
                  nxt_state = ST_SUPPLY;
               end else if (senseSync_ff.cellNearFloat) begin
                  nxt_state = ST_CVREG;
               end
            end
            ST_CVREG: begin
               if (senseSync_ff.loadAtMin && chargeCurrentCmd == '0
                   && senseSync_ff.loadGrowing) begin
                  nxt_state = ST_SUPPLY;
               end else if (termAllow && senseSync_ff.currentAtCutoff
                   && senseSync_ff.cellAboveRecharge) begin
                  nxt_state = ST_DET_SINK;
                  tmrStart  = 1'b1;
               end
            end
            ST_DET_SINK: begin
               if (!senseSync_ff.cellAboveProbe) begin
                  nxt_state  = ST_DET_SRC;
                  nxt_absent = 1'b1;
                  nxt_srcOff = 1'b0;
                  alertReq   = !absent_ff;
                  tmrStart   = 1'b1;
               end else if (tmrDone) begin
                  nxt_state  = ST_DONE;
                  if (absent_ff) begin
                     nxt_state  = ST_PRECHG;
                     nxt_absent = 1'b0;
                  end
               end
            end
            ST_DET_SRC: begin
               if (senseSync_ff.cellAboveProbe && !srcOff_ff) begin
                  nxt_srcOff = 1'b1;
               end
               if (tmrDone) begin
                  nxt_state = ST_DET_SINK;
                  tmrStart  = 1'b1;
               end
            end
            ST_DONE: begin
               if (!senseSync_ff.cellAboveRecharge) begin
                  nxt_state = ST_PRECHG;
               end
            end
            ST_SUPPLY: begin
               if (!senseSync_ff.loadGrowing && !senseSync_ff.loadAtMin) begin
                  nxt_state = ST_FAST;
               end
            end
            default: nxt_state = ST_PRECHG;
         endcase
      end
      if (!termAllow && (nxt_state == ST_DET_SINK || nxt_state == ST_DET_SRC)) begin
         nxt_state = ST_CVREG;
      end
      // battery-only short retry uses the same timer
      if (!senseSync_ff.inputValid && senseSync_ff.cellAboveUvlo
          && senseSync_ff.shortLimit && !tmrBusy) begin
         tmrStart = 1'b1;
         tmrLen   = TW'(DEGLITCH_LEN);
      end
      if (senseSync_ff.cellOverVolt && !ovp_ff) begin
         alertReq = 1'b1;
      end
      if (inputRise) begin
         alertReq = 1'b1;
      end
   end

   logic newSupply_ff;
   logic nxt_newSupply;
   always_comb begin
      nxt_newSupply = newSupply_ff;
      if (inputRise) begin
         nxt_newSupply = 1'b1;
      end else if (regReq.rdEn && regReq.addr == CHARGE_CONTROL_ADDR) begin
         nxt_newSupply = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff     <= ST_PRECHG;
         absent_ff    <= 1'b0;
         srcOff_ff    <= 1'b0;
         ovp_ff       <= 1'b0;
         newSupply_ff <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         absent_ff    <= inputRise ? 1'b0 : nxt_absent;
         srcOff_ff    <= nxt_srcOff;
         ovp_ff       <= senseSync_ff.cellOverVolt;
         newSupply_ff <= nxt_newSupply;
      end
   end

   // current rises toward target a step per enable pulse, falls without waiting for one
   logic [15:0]      rampDiv_ff;
   logic [15:0]      nxt_rampDiv;
   logic [CUR_W-1:0] cur_ff;
   logic [CUR_W-1:0] nxt_cur;
   logic [CUR_W-1:0] target;
   logic             rampTick;
   assign rampTick = (rampDiv_ff == 16'(RAMP_STEP - 1));
   always_comb begin
      nxt_rampDiv = rampTick ? 16'h0000 : rampDiv_ff + 16'h0001;
      target = '0;
      if (state_ff == ST_PRECHG || state_ff == ST_FAST || state_ff == ST_CVREG) begin
         target = chargeCurrentSet;
      end
      if (senseSync_ff.loadAtMin) begin
         target = '0;
      end
      nxt_cur = cur_ff;
      if (target < cur_ff) begin
         nxt_cur = (senseSync_ff.loadAtMin || state_ff != ST_FAST) ? target
                 : cur_ff - CUR_W'(1);
      end else if (rampTick && target > cur_ff) begin
         nxt_cur = cur_ff + CUR_W'(1);
      end
   end

   // actuator commands
   drive_t nxt_drive;
   logic   chargingNow;
   always_comb begin
      nxt_drive = '0;
      chargingNow = (state_ff == ST_SHORTED) || (state_ff == ST_PRECHG)
                 || (state_ff == ST_FAST) || (state_ff == ST_CVREG);
      if (senseSync_ff.inputValid) begin
         nxt_drive.buckOn = !hizSel;
         if (mayCharge) begin
            nxt_drive.battSwitchLinear = (state_ff == ST_SHORTED) || (state_ff == ST_PRECHG);
            nxt_drive.battSwitchOn = (state_ff == ST_FAST) || (state_ff == ST_CVREG)
                                  || (state_ff == ST_SUPPLY) || (state_ff == ST_DONE);
            nxt_drive.shortCurOn  = (state_ff == ST_SHORTED)
                                 || (state_ff == ST_DET_SRC && !srcOff_ff);
            nxt_drive.probeSinkOn = (state_ff == ST_DET_SINK);
            nxt_drive.taperOn     = (state_ff == ST_CVREG);
         end
      end else if (senseSync_ff.cellAboveUvlo) begin
         nxt_drive.battSwitchOn = !tmrBusy;
      end else begin
         nxt_drive.cellPinHiz = 1'b1;
      end
      if (senseSync_ff.cellOverVolt) begin
         nxt_drive.buckOn = 1'b0;
         nxt_drive.battSwitchOn = 1'b1;
         nxt_drive.battSwitchLinear = 1'b0;
      end
   end

   // alert pulse timer and status pin
   logic [TW-1:0] alertCnt_ff;
   logic [TW-1:0] nxt_alertCnt;
   logic          nxt_statOe_b;
   always_comb begin
      nxt_alertCnt = alertCnt_ff;
      if (alertReq) begin
         nxt_alertCnt = TW'(ALERT_LEN);
      end else if (alertCnt_ff != '0) begin
         nxt_alertCnt = alertCnt_ff - TW'(1);
      end
      // pulse inverts the resting level; low during charge means oe low drives
      nxt_statOe_b = 1'b1;
      if (statEn) begin
         nxt_statOe_b = !(chargingNow && mayCharge) ^ (nxt_alertCnt != '0);
      end
   end

   drive_t            drive_ff;
   logic [CUR_W-1:0]  curOut_ff;
   logic [5:0]        float_ff;
   status_t           status_ff;
   logic              statOe_b_ff;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rampDiv_ff  <= 16'h0000;
         cur_ff      <= '0;
         drive_ff    <= '0;
         curOut_ff   <= '0;
         float_ff    <= 6'h00;
         status_ff   <= '0;
         alertCnt_ff <= '0;
         statOe_b_ff <= 1'b1;
      end else begin
         rampDiv_ff  <= nxt_rampDiv;
         cur_ff      <= nxt_cur;
         drive_ff    <= nxt_drive;
         curOut_ff   <= nxt_cur;
         float_ff    <= floatVoltageSet;
         status_ff   <= '{battAbsent: nxt_absent, overVolt: senseSync_ff.cellOverVolt,
                          newSupply: nxt_newSupply,
                          faultAny: nxt_absent | senseSync_ff.cellOverVolt};
         alertCnt_ff <= nxt_alertCnt;
         statOe_b_ff <= nxt_statOe_b;
      end
   end

   assign regRdata         = rdata_ff;
   assign driveOut         = drive_ff;
   assign chargeCurrentCmd = curOut_ff;
   assign floatVoltageCmd  = float_ff;
   assign statusOut        = status_ff;
   assign chargeState      = state_ff;
   assign statPinOe_b      = statOe_b_ff;
endmodule

//--- sim/cell_load_model.sv
`timescale 1ns/1ps
module cell_load_model
   import charge_seq_pkg::*;
#(
   parameter int SHORT_MV = 2000,
   parameter int LOAD_MV  = 3500,
   parameter int FLOAT_MV = 4200,
   parameter int RCH_MV   = 100,
   parameter int PROBE_MV = 3300,
   parameter int UVLO_MV  = 2800
) (
   // actuators from the sequencer
   input  charge_seq_pkg::drive_t driveOut,
   // scenario knobs
   input  wire logic [12:0]       cellMv,
   input  wire logic              inputOn,
   input  wire logic              noCell,
   input  wire logic              taperDone,
   input  wire logic              shortHit,
   input  wire logic              loadMin,
   input  wire logic              loadUp,
   // comparator levels
   output charge_seq_pkg::sense_t senseIn
);
   import charge_seq_pkg::*;

   // an empty pin sags under the sink and climbs under the source
   always_comb begin
      senseIn = '0;
      senseIn.inputValid = inputOn;
      senseIn.cellBelowShort = cellMv < SHORT_MV;
      senseIn.loadAboveReg = cellMv > LOAD_MV;
      senseIn.loadAtMin = loadMin;
      senseIn.loadGrowing = loadUp;
      senseIn.cellNearFloat = cellMv > FLOAT_MV - 20;
      senseIn.currentAtCutoff = taperDone;
      senseIn.cellAboveRecharge = cellMv > FLOAT_MV - RCH_MV;
      senseIn.cellAboveProbe = noCell ? driveOut.shortCurOn : cellMv > PROBE_MV;
      senseIn.cellOverVolt = cellMv > FLOAT_MV * 105 / 100;
      senseIn.cellAboveUvlo = cellMv > UVLO_MV;
      senseIn.shortLimit = shortHit && driveOut.battSwitchOn;
   end
endmodule

//--- sim/charge_cycle_sequencer_properties.sv
`timescale 1ns/1ps
module charge_seq_checker
   import charge_seq_pkg::*;
(
   // clock and reset
   input wire logic               mclk,
   input wire logic               rst_b,
   // watched ports
   input charge_seq_pkg::reg_req_t regReq,
   input wire logic [7:0]         regRdata,
   input charge_seq_pkg::sense_t  senseIn,
   input charge_seq_pkg::drive_t  driveOut,
   input wire logic [CUR_W-1:0]   chargeCurrentCmd,
   input charge_seq_pkg::status_t statusOut,
   input chg_state_t              chargeState
);
   import charge_seq_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // two cycles in a state so the registered drive has caught up
   sequence held(chg_state_t st);
      (chargeState == st) [*2];
   endsequence
   // sense level steady past the synchroniser and the drive register
   sequence steady(logic c);
      c [*6];
   endsequence

   chk_state_onehot: assert property ($onehot(chargeState))
      else $error("state not one-hot");
   chk_shorted_drive: assert property (held(ST_SHORTED)
      |-> driveOut.shortCurOn && driveOut.battSwitchLinear)
      else $error("no recovery current");
   chk_fast_switch: assert property (held(ST_FAST)
      |-> driveOut.battSwitchOn && !driveOut.battSwitchLinear)
      else $error("switch not fully on");
   chk_ramp_slew: assert property (chargeState == ST_FAST
      && chargeCurrentCmd > $past(chargeCurrentCmd)
      |=> $stable(chargeCurrentCmd) || chargeState != ST_FAST)
      else $error("current jumped");
   chk_sink_probe: assert property (held(ST_DET_SINK) |-> driveOut.probeSinkOn)
      else $error("sink off in sink phase");
   chk_source_phase: assert property (held(ST_DET_SRC)
      |-> !driveOut.probeSinkOn)
      else $error("sink on in source phase");
   chk_overvolt_stop: assert property (steady(senseIn.cellOverVolt)
      |-> statusOut.overVolt && !driveOut.buckOn && driveOut.battSwitchOn)
      else $error("over-voltage not handled");
   chk_uvlo_hiz: assert property (steady(!senseIn.inputValid && !senseIn.cellAboveUvlo)
      |-> driveOut.cellPinHiz && !driveOut.battSwitchOn)
      else $error("cell pin not released");
   chk_unmapped_read: assert property (regReq.rdEn && regReq.addr != CHARGE_CONTROL_ADDR
      |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   chk_reserved_zero: assert property (regReq.rdEn |=> regRdata[6:4] == 3'h0)
      else $error("reserved bits set");
endmodule

bind charge_cycle_sequencer charge_seq_checker u_chk (.mclk(mclk), .rst_b(rst_b),
   .regReq(regReq), .regRdata(regRdata), .senseIn(senseIn), .driveOut(driveOut),
   .chargeCurrentCmd(chargeCurrentCmd), .statusOut(statusOut), .chargeState(chargeState));

//--- sim/charge_cycle_sequencer_tb_top.sv
`timescale 1ns/1ps
module charge_cycle_sequencer_tb_top;
   import charge_seq_pkg::*;
   logic mclk, rst_b, inputOn, noCell, taperDone, shortHit, statPinOe_b, loadMin, loadUp;
   reg_req_t regReq;
   logic [7:0] regRdata, curCmd;
   logic [7:0] curSet = 8'h10;
   logic [5:0] fvSet = 6'h15; // kept above the cell level
   logic [5:0] fvCmd;
   logic [12:0] cellMv;
   sense_t senseIn;
   drive_t driveOut;
   status_t statusOut;
   chg_state_t chargeState;
   int n_mismatch = 0, check_count = 0, cycles = 0, n;

   // 200 MHz
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   charge_cycle_sequencer #(.ALERT_LEN(8), .PROBE_LEN(20), .DEGLITCH_LEN(10),
      .RAMP_STEP(2)) DUT (.mclk(mclk), .rst_b(rst_b), .regReq(regReq),
      .regRdata(regRdata), .chargeCurrentSet(curSet), .floatVoltageSet(fvSet),
      .senseIn(senseIn), .driveOut(driveOut), .chargeCurrentCmd(curCmd),
      .floatVoltageCmd(fvCmd), .statusOut(statusOut), .chargeState(chargeState),
      .statPinOe_b(statPinOe_b));
   cell_load_model u_cell (.driveOut(driveOut), .cellMv(cellMv), .inputOn(inputOn),
      .noCell(noCell), .taperDone(taperDone), .shortHit(shortHit),
      .loadMin(loadMin), .loadUp(loadUp), .senseIn(senseIn));

   task automatic results();
      $display("compares %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one-cycle request pulses, then an idle cycle so calls never collide
   task automatic wr(input logic [7:0] a, d);
      regReq = '{1'b1, 1'b0, a, d};
      @(negedge mclk);
      regReq = '0;
      @(negedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, exp);
      regReq = '{1'b0, 1'b1, a, 8'h00};
      @(negedge mclk);
      regReq = '0;
      @(negedge mclk);
      check("regRdata", regRdata, exp);
   endtask
   task automatic wait_st(input chg_state_t st, input int lim);
      for (int i = 0; i < lim && chargeState !== st; i++)
         @(negedge mclk);
      check("state", chargeState, st);
   endtask

   // hang guard, far above the planned run
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         results();
      end
   end

   initial begin
      regReq = '0;
      cellMv = 13'd3000;
      {noCell, taperDone, shortHit, loadMin, loadUp} = 5'b00000;
      inputOn = 1'b1;
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      check("state", chargeState, ST_PRECHG);
      check("statPin", {7'h0, statPinOe_b}, 8'h01);
      rd(CHARGE_CONTROL_ADDR, CHARGE_CONTROL_RST);
      rd(8'h05, 8'h00);
      wr(CHARGE_CONTROL_ADDR, 8'hff);
      rd(CHARGE_CONTROL_ADDR, 8'h0f);
      wr(CHARGE_CONTROL_ADDR, 8'h04);
      check("floatCmd", {2'h0, fvCmd}, {2'h0, fvSet});
      cellMv = 13'd1500;
      wait_st(ST_SHORTED, 20);
      cellMv = 13'd3000;
      wait_st(ST_PRECHG, 40);
      cellMv = 13'd3600;
      wait_st(ST_FAST, 20);
      for (n = 0; n < 200 && curCmd !== curSet; n++)
         @(negedge mclk);
      check("current", curCmd, curSet);
      check("rampSlow", {7'h0, n >= 3}, 8'h01);
      cellMv = 13'd4190;
      wait_st(ST_CVREG, 20);
      taperDone = 1'b1;
      wait_st(ST_DET_SINK, 20);
      wait_st(ST_DONE, 60);
      taperDone = 1'b0;
      cellMv = 13'd4000;
      wait_st(ST_FAST, 60);
      // empty pin: sink fails, source climbs, sink again
      noCell = 1'b1;
      cellMv = 13'd4190;
      wait_st(ST_CVREG, 20);
      taperDone = 1'b1;
      wait_st(ST_DET_SINK, 20);
      wait_st(ST_DET_SRC, 60);
      repeat (2) @(negedge mclk);
      check("absent", {7'h0, statusOut.battAbsent}, 8'h01);
      wait_st(ST_DET_SINK, 80);
      noCell = 1'b0;
      taperDone = 1'b0;
      wait_st(ST_CVREG, 120);
      repeat (2) @(negedge mclk);
      check("absent", {7'h0, statusOut.battAbsent}, 8'h00);
      wr(CHARGE_CONTROL_ADDR, 8'h00);
      taperDone = 1'b1;
      repeat (80) @(negedge mclk);
      check("state", chargeState, ST_CVREG);
      wr(CHARGE_CONTROL_ADDR, 8'h06);
      repeat (10) @(negedge mclk);
      check("battSw", {7'h0, driveOut.battSwitchOn}, 8'h00);
      taperDone = 1'b0;
      // status pin enabled from here on
      wr(CHARGE_CONTROL_ADDR, 8'h05);
      wait_st(ST_CVREG, 80);
      check("statPin", {7'h0, statPinOe_b}, 8'h00);
      // load at its floor and still growing: current to zero, then supplement
      {loadMin, loadUp} = 2'b11;
      wait_st(ST_SUPPLY, 20);
      repeat (2) @(negedge mclk);
      check("current", curCmd, 8'h00);
      check("battSw", {7'h0, driveOut.battSwitchOn}, 8'h01);
      {loadMin, loadUp} = 2'b00;
      wait_st(ST_CVREG, 20);
      cellMv = 13'd4500;
      repeat (10) @(negedge mclk);
      check("overVolt", {7'h0, statusOut.overVolt}, 8'h01);
      check("fault", {7'h0, statusOut.faultAny}, 8'h01);
      check("buck", {7'h0, driveOut.buckOn}, 8'h00);
      // battery only, short on the load rail
      inputOn = 1'b0;
      cellMv = 13'd3700;
      repeat (10) @(negedge mclk);
      check("battSw", {7'h0, driveOut.battSwitchOn}, 8'h01);
      shortHit = 1'b1;
      repeat (6) @(negedge mclk);
      check("battSw", {7'h0, driveOut.battSwitchOn}, 8'h00);
      shortHit = 1'b0;
      repeat (20) @(negedge mclk);
      check("battSw", {7'h0, driveOut.battSwitchOn}, 8'h01);
      cellMv = 13'd2500;
      repeat (10) @(negedge mclk);
      check("hiz", {7'h0, driveOut.cellPinHiz}, 8'h01);
      inputOn = 1'b1;
      cellMv = 13'd3700;
      repeat (8) @(negedge mclk);
      check("newSupply", {7'h0, statusOut.newSupply}, 8'h01);
      check("buck", {7'h0, driveOut.buckOn}, 8'h01);
      results();
   end
endmodule
